/* File: core/cbg_defines.vh */
// Purpose: constants shared by the board glue decode block
// Assumes: included by bare name, once per compilation unit
// Notes: offsets are APB byte addresses, one 32-bit word each
`ifndef CBG_DEFINES_VH
`define CBG_DEFINES_VH

`define CBG_OFF_CTRL 12'h000
`define CBG_OFF_STATUS 12'h004
`define CBG_OFF_STRAPS 12'h008
`define CBG_OFF_IOCNT 12'h00c
`define CBG_OFF_WAITCNT 12'h010

`define CBG_CTRL_DEC_EN 0
`define CBG_CTRL_CLR_LATCH 1
`define CBG_CTRL_RESET 1'b1

`define CBG_ST_LATCH 0
`define CBG_ST_READY 1
`define CBG_ST_WAIT 2
`define CBG_ST_SEL_LO 4
`define CBG_ST_SEL_HI 7

`define CBG_STRAP_W 16
`define CBG_SP_RAM_DIS 0
`define CBG_SP_RESET_HI 1
`define CBG_SP_WAIT_MEM 2
`define CBG_SP_WAIT_IO 3
`define CBG_SP_MEMORY_EXPANSION_LINE_GND 4
`define CBG_SP_IO_EXPANSION_LINE_GND 5
`define CBG_SP_EP0_SLOT_LO 6
`define CBG_SP_EP0_BLK_LO 9
`define CBG_SP_EP1_SLOT_LO 11
`define CBG_SP_EP1_BLK_LO 14

`define CBG_RAM_PAGE 8'hff
`define CBG_TMR_BASE 6'h1f
`define CBG_REDIR_MASK 16'he000
`define CBG_SETTLE_CYC 3'd4
`define CBG_SETTLE_W 3

`endif

/* File: core/cbg_glue.v */
// Purpose: address decode, reset redirect and bus steering for an 8-bit cpu board
// Assumes: cpu bus signals come from logic on clk_sys; straps come from pins
// Notes: every decode output lags the bus by one clock; registers over APB
// Functional notes
// - I/O ports 7C..7F select the timer, channels 0..3 in order.
// - memory FF00..FFFF selects the on-board RAM.
// - a strap disables the RAM select entirely.
// - each EPROM select strapped to a 2K slot in a chosen 16K block.
// - a strap chooses start address 0000 or E000 after reset.
// - E000 option sets the redirect latch when the settle window after reset ends; it holds until cleared.
// - any I/O cycle clears the redirect latch.
// - an enabled wait generator inserts exactly one wait state.
// - memory and I/O wait insertion have independent strap enables.
// - straps tie the memory and I/O expansion lines low.
// - the other 252 I/O ports stay undecoded for off-board use.
// - 16-bit address and 8-bit data path, full 64K off board.
// - interrupts from timer and user devices reach the cpu.
// - data buffer out for on-board, in for off-board, off under bus ack.
// - a wait state lengthens the cycle by one clock period.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "cbg_defines.vh"
module cbg_glue (
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire [15:0] cpu_addr,
  input wire cpu_mreq_n,
  input wire cpu_iorq_n,
  input wire cpu_m1_n,
  input wire cpu_busak_n,
  input wire timer_int_n,
  input wire user_int_n,
  input wire [15:0] strap_pins,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output reg [15:0] bus_addr,
  output reg bus_addr_oe,
  output reg ram_sel,
  output reg [1:0] eprom_sel,
  output reg counter_timer_unit_sel,
  output reg [1:0] counter_timer_unit_chan,
  output reg data_oe,
  output reg data_dir_out,
  output reg memory_expansion_line,
  output reg io_expansion_line,
  output reg cpu_int_n,
  output wire cpu_wait_n
);
  wire [15:0] strap;
  wire [15:0] wait_count;
  wire wait_busy_n;
  reg ctrl_dec_en_reg;
  reg latch_reg;
  reg latch_next;
  reg ready_reg;
  reg [`CBG_SETTLE_W-1:0] settle_reg;
  reg mem_prev_reg;
  reg io_prev_reg;
  reg [15:0] io_count_reg;
  reg [3:0] last_sel_reg;
  reg [31:0] rd_next;
  reg hit_next;

  // one strap slot: 16K block in addr[15:14], 2K slot in addr[13:11]
  function eprom_hit;
    input [15:0] a;
    input [1:0] blk;
    input [2:0] slot;
    begin
      eprom_hit = (a[15:14] == blk) && (a[13:11] == slot);
    end
  endfunction

  function is_reg;
    input [11:0] a;
    input [11:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  // strap pins are static configuration, re-sampled every clock
  cbg_strap_sync #(
    .W(`CBG_STRAP_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .pin_in(strap_pins),
    .strap_out(strap)
  );

  wire ram_dis = strap[`CBG_SP_RAM_DIS];
  wire reset_hi = strap[`CBG_SP_RESET_HI];
  wire [2:0] ep0_slot = strap[`CBG_SP_EP0_SLOT_LO+2:`CBG_SP_EP0_SLOT_LO];
  wire [1:0] ep0_blk = strap[`CBG_SP_EP0_BLK_LO+1:`CBG_SP_EP0_BLK_LO];
  wire [2:0] ep1_slot = strap[`CBG_SP_EP1_SLOT_LO+2:`CBG_SP_EP1_SLOT_LO];
  wire [1:0] ep1_blk = strap[`CBG_SP_EP1_BLK_LO+1:`CBG_SP_EP1_BLK_LO];

  // bus cycle classification; int acknowledge is iorq with m1
  wire bus_held = ~cpu_busak_n;
  wire mem_act = ~cpu_mreq_n & ~bus_held;
  wire io_act = ~cpu_iorq_n & cpu_m1_n & ~bus_held;
  wire int_ack = ~cpu_iorq_n & ~cpu_m1_n & ~bus_held;
  wire mem_start = mem_act & ~mem_prev_reg;
  wire io_start = io_act & ~io_prev_reg;
  wire dec_on = ctrl_dec_en_reg & ready_reg;

  // redirect forces A15..A13 high on memory cycles while the latch stands
  wire [15:0] map_addr = (latch_reg & mem_act) ? (cpu_addr | `CBG_REDIR_MASK) : cpu_addr;

  // fixed priority keeps the selects mutually exclusive
  wire ram_hit = dec_on & mem_act & ~ram_dis & (map_addr[15:8] == `CBG_RAM_PAGE);
  wire ep0_hit = dec_on & mem_act & ~ram_hit & eprom_hit(map_addr, ep0_blk, ep0_slot);
  wire ep1_hit = dec_on & mem_act & ~ram_hit & ~ep0_hit
    & eprom_hit(map_addr, ep1_blk, ep1_slot);
  // only the low byte counts on I/O; everything else is off board
  wire tmr_hit = dec_on & io_act & (cpu_addr[7:2] == `CBG_TMR_BASE);
  wire onboard = ram_hit | ep0_hit | ep1_hit | tmr_hit;

  // APB handshake
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  wire apb_wr = apb_done & pwrite;
  wire clr_by_sw = apb_wr & is_reg(paddr, `CBG_OFF_CTRL) & pwdata[`CBG_CTRL_CLR_LATCH];

  cbg_wait_gen u_wait (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .cycle_start((mem_start | io_start) & ready_reg),
    .cycle_is_io(io_start),
    .wait_mem_en(strap[`CBG_SP_WAIT_MEM]),
    .wait_io_en(strap[`CBG_SP_WAIT_IO]),
    .wait_n(wait_busy_n),
    .wait_count(wait_count)
  );

  assign cpu_wait_n = wait_busy_n;

  // settle window lets the strap sampler fill before the latch is armed
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      settle_reg <= {`CBG_SETTLE_W{1'b0}};
      ready_reg <= 1'b0;
    end else if (ce) begin
      if (!ready_reg) begin
        if (settle_reg == `CBG_SETTLE_CYC) begin
          ready_reg <= 1'b1;
        end else begin
          settle_reg <= settle_reg + {{(`CBG_SETTLE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // redirect latch: arming wins over a clear in the same clock
  always @* begin
    latch_next = latch_reg;
    if (io_start | clr_by_sw) begin
      latch_next = 1'b0;
    end
    if (!ready_reg && settle_reg == `CBG_SETTLE_CYC) begin
      latch_next = reset_hi;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= 1'b0;
      mem_prev_reg <= 1'b0;
      io_prev_reg <= 1'b0;
      io_count_reg <= 16'h0000;
    end else if (ce) begin
      latch_reg <= latch_next;
      mem_prev_reg <= mem_act;
      io_prev_reg <= io_act;
      if (io_start) begin
        io_count_reg <= io_count_reg + 16'h0001;
      end
    end
  end

  // registered bus-side outputs
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_addr <= 16'h0000;
      bus_addr_oe <= 1'b0;
      ram_sel <= 1'b0;
      eprom_sel <= 2'b00;
      counter_timer_unit_sel <= 1'b0;
      counter_timer_unit_chan <= 2'b00;
      data_oe <= 1'b0;
      data_dir_out <= 1'b0;
      memory_expansion_line <= 1'b1;
      io_expansion_line <= 1'b1;
      cpu_int_n <= 1'b1;
      last_sel_reg <= 4'h0;
    end else if (ce) begin
      bus_addr <= map_addr;
      bus_addr_oe <= ~bus_held;
      ram_sel <= ram_hit;
      eprom_sel <= {ep1_hit, ep0_hit};
      counter_timer_unit_sel <= tmr_hit;
      counter_timer_unit_chan <= cpu_addr[1:0];
      data_oe <= (mem_act | io_act | int_ack) & ~bus_held;
      data_dir_out <= onboard;
      memory_expansion_line <= ~strap[`CBG_SP_MEMORY_EXPANSION_LINE_GND];
      io_expansion_line <= ~strap[`CBG_SP_IO_EXPANSION_LINE_GND];
      // both sources share the one wired request line
      cpu_int_n <= timer_int_n & user_int_n;
      if (onboard) begin
        last_sel_reg <= {tmr_hit, ep1_hit, ep0_hit, ram_hit};
      end
    end
  end

  // APB read mux and decode
  always @* begin
    rd_next = 32'h00000000;
    hit_next = 1'b1;
    case (paddr)
      `CBG_OFF_CTRL: begin
        rd_next[`CBG_CTRL_DEC_EN] = ctrl_dec_en_reg;
      end
      `CBG_OFF_STATUS: begin
        rd_next[`CBG_ST_LATCH] = latch_reg;
        rd_next[`CBG_ST_READY] = ready_reg;
        rd_next[`CBG_ST_WAIT] = ~wait_busy_n;
        rd_next[`CBG_ST_SEL_HI:`CBG_ST_SEL_LO] = last_sel_reg;
      end
      `CBG_OFF_STRAPS: begin
        rd_next[15:0] = strap;
      end
      `CBG_OFF_IOCNT: begin
        rd_next[15:0] = io_count_reg;
      end
      `CBG_OFF_WAITCNT: begin
        rd_next[15:0] = wait_count;
      end
      default: begin
        hit_next = 1'b0;
      end
    endcase
  end

  // zero-wait slave: ready rises for the access phase after each setup
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl_dec_en_reg <= `CBG_CTRL_RESET;
    end else if (ce) begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_next;
        pslverr <= ~hit_next;
      end else if (apb_done) begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
      if (apb_wr && is_reg(paddr, `CBG_OFF_CTRL)) begin
        ctrl_dec_en_reg <= pwdata[`CBG_CTRL_DEC_EN];
      end
    end
  end
endmodule // cbg_glue
`default_nettype wire

/* File: core/cbg_strap_sync.v */
// Purpose: three-stage sampler for static strap pins
// Assumes: straps change rarely, outside any bus activity
// Notes: a bit moves only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module cbg_strap_sync #(
  parameter W = 16
) (
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] strap_out
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer i;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      strap_out <= {W{1'b0}};
    end else if (ce) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          strap_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // cbg_strap_sync
`default_nettype wire

/* File: core/cbg_wait_gen.v */
// Purpose: one-wait-state generator for memory and I/O cycles
// Assumes: cycle_start is a one-clock pulse at the first T-state
// Notes: one clock of this block stands for one processor T-state
`timescale 1ns/100ps
`default_nettype none
module cbg_wait_gen (
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  input wire cycle_start,
  input wire cycle_is_io,
  input wire wait_mem_en,
  input wire wait_io_en,
  output reg wait_n,
  output reg [15:0] wait_count
);
  wire insert;

  // separate enables per cycle type
  assign insert = cycle_start & (cycle_is_io ? wait_io_en : wait_mem_en);

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_n <= 1'b1;
      wait_count <= 16'h0000;
    end else if (ce) begin
      // low for exactly one clock, so the cycle grows by one period
      wait_n <= ~insert;
      if (insert) begin
        wait_count <= wait_count + 16'h0001;
      end
    end
  end
endmodule // cbg_wait_gen
`default_nettype wire

/* File: verification/cbg_checker.sv */
// Purpose: bus-side assertions for the board glue decode
// Assumes: ce held high; straps change only while the cpu bus is idle
// Notes: decode outputs lag the cpu bus by one clock
`timescale 1ns/100ps
`default_nettype none
module cbg_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_mreq_n,
  input wire logic cpu_iorq_n,
  input wire logic cpu_m1_n,
  input wire logic cpu_busak_n,
  input wire logic timer_int_n,
  input wire logic user_int_n,
  input wire logic [15:0] strap_pins,
  input wire logic ram_sel,
  input wire logic [1:0] eprom_sel,
  input wire logic counter_timer_unit_sel,
  input wire logic [1:0] counter_timer_unit_chan,
  input wire logic bus_addr_oe,
  input wire logic data_oe,
  input wire logic data_dir_out,
  input wire logic memory_expansion_line,
  input wire logic io_expansion_line,
  input wire logic cpu_int_n,
  input wire logic cpu_wait_n
);
  logic [3:0] up_reg;
  wire rdy = up_reg == 4'hf;
  wire io_cyc = !cpu_iorq_n && cpu_m1_n && cpu_busak_n;
  // decode is held off while the strap sampler settles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      up_reg <= 4'h0;
    else if (!rdy)
      up_reg <= up_reg + 4'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence wait_pulse;
    !cpu_wait_n && (!cpu_mreq_n || !cpu_iorq_n) ##1 cpu_wait_n;
  endsequence
  sequence straps_held;
    $stable(strap_pins)[*8] ##0 rdy;
  endsequence
  a_timer_hit: assert property (rdy |=>
    counter_timer_unit_sel == $past(io_cyc && cpu_addr[7:2] == 6'h1f))
    else $error("timer select mismatch");
  a_timer_chan: assert property (rdy && io_cyc && cpu_addr[7:2] == 6'h1f |=>
    counter_timer_unit_chan == $past(cpu_addr[1:0])) else $error("timer channel mismatch");
  a_ram_decode: assert property (rdy |=> ram_sel == $past(!cpu_mreq_n &&
    cpu_busak_n && cpu_addr[15:8] == 8'hff && !strap_pins[0])) else $error("ram select mismatch");
  a_one_select: assert property (
    $onehot0({ram_sel, eprom_sel, counter_timer_unit_sel})) else $error("several selects");
  a_busak_quiet: assert property (!cpu_busak_n |=> !data_oe && !bus_addr_oe &&
    !ram_sel && eprom_sel == 2'b00 && !counter_timer_unit_sel) else $error("bus not released");
  a_dir_onboard: assert property (
    data_dir_out == (ram_sel || eprom_sel != 2'b00 || counter_timer_unit_sel))
    else $error("data direction not outward on board hit");
  a_int_merge: assert property (
    cpu_int_n == $past(timer_int_n && user_int_n)) else $error("interrupt merge wrong");
  a_wait_pulse: assert property (
    $fell(cpu_wait_n) |-> wait_pulse) else $error("wait not one clock in a cycle");
  a_strap_ties: assert property (straps_held |->
    memory_expansion_line == !strap_pins[4] && io_expansion_line == !strap_pins[5])
    else $error("expansion tie wrong");
endmodule // cbg_checker
bind cbg_glue cbg_checker u_cbg_checker (.clk_sys, .nrst, .cpu_addr, .cpu_mreq_n, .cpu_iorq_n,
  .cpu_m1_n, .cpu_busak_n, .timer_int_n, .user_int_n, .strap_pins, .ram_sel, .eprom_sel,
  .counter_timer_unit_sel, .counter_timer_unit_chan, .bus_addr_oe, .data_oe, .data_dir_out,
  .memory_expansion_line, .io_expansion_line, .cpu_int_n, .cpu_wait_n);
`default_nettype wire

/* File: verification/cbg_cpu_model.sv */
// Purpose: processor-side model running memory and I/O cycles
// Assumes: run is called just after a clock edge
// Notes: no opcode fetch or interrupt acknowledge cycles
`timescale 1ns/100ps
`default_nettype none
module cbg_cpu_model (
  input wire logic clk_sys,
  input wire logic cpu_wait_n,
  input wire logic [15:0] bus_addr,
  input wire logic [3:0] sel,
  output logic [15:0] cpu_addr,
  output logic cpu_mreq_n,
  output logic cpu_iorq_n,
  output logic cpu_m1_n
);
  logic [15:0] seen_addr;
  logic [3:0] seen_sel;
  int len;
  initial begin
    cpu_addr = 16'h0000;
    cpu_mreq_n = 1'b1;
    cpu_iorq_n = 1'b1;
    cpu_m1_n = 1'b1;
  end
  // three clocks, one more per wait seen low; capped so a stuck wait cannot hang
  task automatic run(input logic io, input logic [15:0] a);
    int w;
    w = 0;
    len = 0;
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_mreq_n <= io;
    cpu_iorq_n <= !io;
    while (len < 3 + w && len < 9) begin
      @(posedge clk_sys);
      len++;
      if (len == 2) begin
        seen_addr = bus_addr;
        seen_sel = sel;
      end
      if (cpu_wait_n === 1'b0)
        w++;
    end
    cpu_mreq_n <= 1'b1;
    cpu_iorq_n <= 1'b1;
    cpu_addr <= ~a;
  endtask
endmodule // cbg_cpu_model
`default_nettype wire

/* File: verification/cbg_glue_tb_top.sv */
// Purpose: self-checking bench for the board glue decode
// Assumes: ce held high; the cpu model runs all bus cycles
// Notes: APB and boot waits are bounded and end the run when they run out; bus cycles are only capped
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module cbg_glue_tb_top;
  logic clk_sys = 1'b0, nrst = 1'b0, cpu_busak_n = 1'b1, timer_int_n = 1'b1, user_int_n = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e, ram_sel;
  logic counter_timer_unit_sel, cpu_wait_n, cpu_mreq_n, cpu_iorq_n, cpu_m1_n;
  logic [1:0] eprom_sel;
  logic [11:0] paddr = 12'h000;
  logic [15:0] strap_pins = 16'h0002, cpu_addr, bus_addr;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int err_count = 0, total_checks = 0;
  wire [3:0] sel_seen = u_cbg_cpu_model.seen_sel;
  wire [15:0] adr_seen = u_cbg_cpu_model.seen_addr;
  cbg_glue u_cbg_glue (.clk_sys, .nrst, .ce(1'b1), .cpu_addr, .cpu_mreq_n, .cpu_iorq_n,
    .cpu_m1_n, .cpu_busak_n, .timer_int_n, .user_int_n, .strap_pins, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .bus_addr, .bus_addr_oe(),
    .ram_sel, .eprom_sel, .counter_timer_unit_sel, .counter_timer_unit_chan(), .data_oe(),
    .data_dir_out(), .memory_expansion_line(), .io_expansion_line(), .cpu_int_n(),
    .cpu_wait_n);
  cbg_cpu_model u_cbg_cpu_model (.clk_sys, .cpu_wait_n, .bus_addr,
    .sel({ram_sel, eprom_sel, counter_timer_unit_sel}), .cpu_addr, .cpu_mreq_n,
    .cpu_iorq_n, .cpu_m1_n);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic summarize();
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin @(posedge clk_sys); k++; end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin err_count++; summarize(); end
  endtask
  task automatic boot();
    int k;
    k = 0;
    do begin apb(1'b0, 12'h004, 32'h0); k++; end while (q[1] !== 1'b1 && k < 20);
    if (q[1] !== 1'b1) begin err_count++; summarize(); end
  endtask
  task automatic cyc(input logic io, input logic [15:0] a);
    u_cbg_cpu_model.run(io, a);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    boot();
    `CHK("latch", 1'b1, q[0])
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl", 32'h1, q)
    `CHK("okerr", 1'b0, e)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("slverr", 1'b1, e)
    cyc(1'b0, 16'h0000);
    `CHK("redir", 16'he000, adr_seen)
    cyc(1'b0, 16'he003);
    cyc(1'b1, 16'h00ff);
    cyc(1'b0, 16'h0123);
    `CHK("unredir", 16'h0123, adr_seen)
    // eprom1 strapped to block 2 slot 3, eprom0 to address zero
    for (int i = 0; i < 8; i++) begin
      strap_pins <= {10'h260, i[1], i[0], i[1], i[0], 1'b1, i[2]};
      repeat (12) @(posedge clk_sys);
      cyc(1'b0, 16'hff00);
      `CHK("ram", i[2] ? 4'b0000 : 4'b1000, sel_seen)
      cyc(1'b0, 16'h0000);
      `CHK("ep0", 4'b0010, sel_seen)
      `CHK("mlen", 3 + i[0], u_cbg_cpu_model.len)
      cyc(1'b0, 16'h9800);
      `CHK("ep1", 4'b0100, sel_seen)
      cyc(1'b1, {8'h12, 6'h1f, i[1:0]});
      `CHK("tmr", 4'b0001, sel_seen)
      `CHK("iolen", 3 + i[1], u_cbg_cpu_model.len)
      cyc(1'b1, {8'h12, i[0] ? 8'h7b : 8'h80});
      `CHK("free", 4'b0000, sel_seen)
    end
    // 17 I/O cycles so far; 12 memory and 8 I/O waits were enabled
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("iocnt", 32'h11, q)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("waitcnt", 32'h14, q)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("straps", 32'h983f, q)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("status", 32'h82, q)
    cpu_busak_n <= 1'b0;
    cyc(1'b0, 16'hff00);
    `CHK("busak", 4'b0000, sel_seen)
    cpu_busak_n <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      {timer_int_n, user_int_n} <= j[1:0];
      repeat (2) @(posedge clk_sys);
    end
    nrst <= 1'b0;
    strap_pins <= 16'h0000;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    boot();
    `CHK("nolatch", 1'b0, q[0])
    cyc(1'b0, 16'h0000);
    `CHK("boot0", 16'h0000, adr_seen)
    // software clear of the redirect latch, decode left enabled
    nrst <= 1'b0;
    strap_pins <= 16'h0002;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    boot();
    `CHK("relatch", 1'b1, q[0])
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("swclr", 1'b0, q[0])
    cyc(1'b0, 16'h0000);
    `CHK("noredir", 16'h0000, adr_seen)
    summarize();
  end
endmodule // cbg_glue_tb_top
`default_nettype wire
